// file: sop_array.sv
// Programmable AND / fixed OR array with eight I/O macrocells and APB access
// to its connection pattern. Assumes pin inputs are asynchronous to clk and
// that the surrounding pad logic resolves io_out / io_oe_n into the wire.
//
// Functional notes
// - Array has 36 lines: true and inverted of 10 inputs and 8 feedbacks.
// - 74 terms: 64 in eight sums of eight, 8 enables, preset, clear.
// - A term ANDs its connected lines; both polarities connected gives false.
// - A term with nothing connected is always true.
// - Bulk erase opens every connection; programming only adds connections.
// - Each macrocell has a flop and two muxes set by four config bits.
// - Bits: polarity(1 low), registered(1), feedback 11 pin, 10 sum, 00 flop.
// - Flop captures its sum on every rising clock edge while run is set and neither preset nor clear is true; stopped, it holds.
// - Combinatorial type routes the sum straight to the output path.
// - All eight flops share the single preset and single clear term.
// - Preset sets flops high at the next rising edge.
// - Clear forces flop outputs low at once, without a clock edge.
// - Clear wins over preset when both are true.
// - Polarity bit selects active-high or active-low pin drive.
// - Pin is driven only while its enable term is true.
// - Open enable term drives whenever running; fully connected term never drives.
// - Feedback comes from pin, flop or sum, as configured.
// - Sum feedback is valid regardless of output type or enable.
// - Flop feedback is available with combinatorial output too.
// - Security bit blocks reads and programming until bulk erase.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module sop_array #(
  parameter int N_IN   = sop_pkg::N_IN,
  parameter int N_IO   = sop_pkg::N_IO,
  parameter int PT_PER = sop_pkg::PT_PER
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Register bus
  input  wire sop_pkg::apb_req_t         apb_in,
  output sop_pkg::apb_rsp_t              apb_out,
  // Dedicated inputs
  input  wire logic [sop_pkg::N_IN-1:0]  in_pin,
  // I/O pins
  input  wire logic [sop_pkg::N_IO-1:0]  io_in,
  output logic      [sop_pkg::N_IO-1:0]  io_out,
  output logic      [sop_pkg::N_IO-1:0]  io_oe_n
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Storage layout lives in the package; the parameters must match it.
  if (N_IN != sop_pkg::N_IN || N_IO != sop_pkg::N_IO || PT_PER != sop_pkg::PT_PER)
  begin : g_bad_geom
    $error("sop_array: geometry parameters differ from package layout");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sop_pkg::state_t cur;
  sop_pkg::state_t next_cur;

  logic [sop_pkg::N_LINES-1:0] lines;
  logic [sop_pkg::N_PT-1:0]    term;
  logic [sop_pkg::N_IO-1:0]    sum;
  logic [sop_pkg::N_IO-1:0]    fb;
  logic [sop_pkg::N_IO-1:0]    qv;
  logic [sop_pkg::N_IO-1:0]    oe_t;
  logic                        clr_on;
  logic                        setup;
  logic                        acc;
  logic                        wr;
  logic                        erase_go;
  logic                        lock;

  // ----------------------------------------------------------------
  // Array evaluation
  // ----------------------------------------------------------------
  // Sum feedback is taken from a registered copy of the sums; a direct path
  // would close a combinational loop through the array.
  always_comb
  begin
    clr_on = cur.run & term[sop_pkg::PT_CLR];
    qv     = cur.q & {sop_pkg::N_IO{~clr_on}};
    for (int m = 0; m < sop_pkg::N_IO; m++)
    begin
      case (cur.cfg[m][1:0])
        sop_pkg::FB_PIN: fb[m] = cur.io_s2[m];
        sop_pkg::FB_SUM: fb[m] = cur.sum_d[m];
        default:         fb[m] = qv[m];
      endcase
    end
    for (int i = 0; i < sop_pkg::N_IN; i++)
    begin
      lines[2*i]   = cur.in_s2[i];
      lines[2*i+1] = ~cur.in_s2[i];
    end
    for (int m = 0; m < sop_pkg::N_IO; m++)
    begin
      lines[2*(sop_pkg::N_IN+m)]   = fb[m];
      lines[2*(sop_pkg::N_IN+m)+1] = ~fb[m];
    end
    for (int t = 0; t < sop_pkg::N_PT; t++)
    begin
      term[t] = &(~cur.fuse[t] | lines);
    end
    for (int m = 0; m < sop_pkg::N_IO; m++)
    begin
      sum[m]  = |term[m*sop_pkg::PT_PER +: sop_pkg::PT_PER];
      oe_t[m] = term[sop_pkg::PT_OE + m];
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // These paths stay combinational so a combinatorial macrocell is not clocked.
  always_comb
  begin
    for (int m = 0; m < sop_pkg::N_IO; m++)
    begin
      io_out[m] = (cur.cfg[m][sop_pkg::CFG_REG] ? qv[m] : sum[m])
                  ^ cur.cfg[m][sop_pkg::CFG_POL];
      io_oe_n[m] = ~(cur.run & oe_t[m]);
    end
  end

  assign apb_out = cur.rsp;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign setup    = apb_in.psel & ~apb_in.penable;
  assign acc      = apb_in.psel & apb_in.penable & cur.rsp.pready;
  assign wr       = acc & apb_in.pwrite;
  assign erase_go = wr & (apb_in.paddr == sop_pkg::REG_CTRL)
                    & apb_in.pwdata[sop_pkg::CTRL_ERASE] & ~cur.run;
  assign lock     = cur.secure | cur.run;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cur       = cur;
    next_cur.in_s1 = in_pin;
    next_cur.in_s2 = cur.in_s1;
    next_cur.io_s1 = io_in;
    next_cur.io_s2 = cur.io_s1;
    next_cur.sum_d = sum;

    if (cur.run)
    begin
      for (int m = 0; m < sop_pkg::N_IO; m++)
      begin
        if (term[sop_pkg::PT_CLR])
          next_cur.q[m] = 1'b0;
        else if (term[sop_pkg::PT_PRE])
          next_cur.q[m] = 1'b1;
        else
          next_cur.q[m] = sum[m];
      end
    end

    // Read data is prepared in the setup cycle; one wait-free access follows.
    next_cur.rsp.pready  = setup;
    next_cur.rsp.pslverr = 1'b0;
    next_cur.rsp.prdata  = '0;
    if (setup)
    begin
      case (apb_in.paddr)
        sop_pkg::REG_CTRL: next_cur.rsp.prdata[sop_pkg::CTRL_RUN] = cur.run;
        sop_pkg::REG_STAT: next_cur.rsp.prdata[2:0] = {cur.refused, cur.run, cur.secure};
        sop_pkg::REG_ROW:  next_cur.rsp.prdata[sop_pkg::ROW_W-1:0] = cur.row;
        sop_pkg::REG_LO:
        begin
          if (!cur.secure && cur.row < sop_pkg::ROW_W'(sop_pkg::N_PT))
            next_cur.rsp.prdata = cur.fuse[cur.row][sop_pkg::LO_W-1:0];
        end
        sop_pkg::REG_HI:
        begin
          if (!cur.secure && cur.row < sop_pkg::ROW_W'(sop_pkg::N_PT))
            next_cur.rsp.prdata[sop_pkg::HI_W-1:0] =
              cur.fuse[cur.row][sop_pkg::N_LINES-1:sop_pkg::LO_W];
        end
        sop_pkg::REG_CFG:
        begin
          if (!cur.secure)
            next_cur.rsp.prdata = cur.cfg;
        end
        sop_pkg::REG_VIEW: next_cur.rsp.prdata[15:0] = {cur.io_s2, qv};
        default:           next_cur.rsp.pslverr = 1'b1;
      endcase
    end

    if (wr)
    begin
      case (apb_in.paddr)
        sop_pkg::REG_CTRL:
        begin
          if (erase_go)
          begin
            next_cur.fuse   = '0;
            next_cur.cfg    = '0;
            next_cur.secure = 1'b0;
          end
          if (apb_in.pwdata[sop_pkg::CTRL_SEC])
            next_cur.secure = 1'b1;
          next_cur.run = apb_in.pwdata[sop_pkg::CTRL_RUN];
        end
        sop_pkg::REG_ROW: next_cur.row = apb_in.pwdata[sop_pkg::ROW_W-1:0];
        sop_pkg::REG_LO:  next_cur.stage = apb_in.pwdata;
        sop_pkg::REG_HI:
        begin
          // Writing the upper part commits the whole row; bits only connect.
          if (lock || cur.row >= sop_pkg::ROW_W'(sop_pkg::N_PT))
            next_cur.refused = 1'b1;
          else
          begin
            next_cur.refused = 1'b0;
            next_cur.fuse[cur.row] = cur.fuse[cur.row]
              | {apb_in.pwdata[sop_pkg::HI_W-1:0], cur.stage};
          end
        end
        sop_pkg::REG_CFG:
        begin
          if (lock)
            next_cur.refused = 1'b1;
          else
          begin
            next_cur.refused = 1'b0;
            next_cur.cfg = apb_in.pwdata;
          end
        end
        default: next_cur.refused = cur.refused;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    apb_in.psel && !apb_in.penable;
  endsequence

  sequence s_one_ready;
    apb_out.pready ##1 !apb_out.pready;
  endsequence

  a_apb_ready: assert property (s_setup |=> s_one_ready)
    else $error("pready not a single cycle after setup");
  a_clear_now: assert property (cur.run && term[sop_pkg::PT_CLR] |-> qv == '0)
    else $error("clear did not force flops low at once");
  a_clear_wins: assert property (cur.run && term[sop_pkg::PT_PRE] && term[sop_pkg::PT_CLR]
    |=> cur.q == '0)
    else $error("preset overrode clear");
  a_preset_sync: assert property (cur.run && term[sop_pkg::PT_PRE] && !term[sop_pkg::PT_CLR]
    && cur.q != '1 |-> ##1 cur.q == '1)
    else $error("preset did not set flops at next edge");
  a_reg_capture: assert property (cur.run && !term[sop_pkg::PT_PRE] && !term[sop_pkg::PT_CLR]
    |=> cur.q == $past(sum))
    else $error("flop did not capture its sum");
  a_erase_opens: assert property (erase_go && !apb_in.pwdata[sop_pkg::CTRL_SEC]
    |=> cur.fuse == '0 && !cur.secure && cur.cfg == '0)
    else $error("bulk erase left connections or security");
  a_secure_lock: assert property (cur.secure && !erase_go
    |=> $stable(cur.fuse) && $stable(cur.cfg))
    else $error("pattern changed while secured");
  a_secure_read: assert property (cur.secure && setup && apb_in.paddr == sop_pkg::REG_LO
    |=> apb_out.prdata == '0)
    else $error("secured pattern was readable");
  a_run_frozen: assert property (cur.run |=> $stable(cur.fuse) && $stable(cur.cfg))
    else $error("pattern changed while running");
  a_oe_open: assert property (!cur.run |-> io_oe_n == '1)
    else $error("pin driven while stopped");

  for (genvar g = 0; g < sop_pkg::N_IO; g++)
  begin : g_cell_chk
    a_comb_path: assert property (!cur.cfg[g][sop_pkg::CFG_REG]
      |-> io_out[g] == (sum[g] ^ cur.cfg[g][sop_pkg::CFG_POL]))
      else $error("combinatorial output not following sum");
    a_sum_fb: assert property (cur.cfg[g][1:0] == sop_pkg::FB_SUM
      ##1 cur.cfg[g][1:0] == sop_pkg::FB_SUM
      |-> lines[2*(sop_pkg::N_IN+g)] == $past(sum[g]))
      else $error("sum feedback lost");
  end

endmodule

// file: sop_board.sv
// Board model for the I/O pins of the logic array.
// Assumes io_oe_n is low while the array drives a pin.
`timescale 1ns/1ps
module sop_board (
  // Array side
  input  wire logic [sop_pkg::N_IO-1:0] io_out,
  input  wire logic [sop_pkg::N_IO-1:0] io_oe_n,
  // Bench side
  input  wire logic [sop_pkg::N_IO-1:0] drv_val,
  input  wire logic [sop_pkg::N_IO-1:0] drv_on,
  // Resolved wire
  output logic      [sop_pkg::N_IO-1:0] io_in
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Released pins rest high on a pull-up, never on a stale value
  always_comb
  begin
    for (int i = 0; i < sop_pkg::N_IO; i++)
    begin
      if (!io_oe_n[i])
        io_in[i] = io_out[i];
      else if (drv_on[i])
        io_in[i] = drv_val[i];
      else
        io_in[i] = 1'b1;
    end
  end
endmodule

// file: sop_pkg.sv
// Constants, register map and carrier types for the sum-of-products logic array.
// Assumes a single 40 MHz system clock and an APB master with 32-bit data.
package sop_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int N_IN     = 10;
  localparam int N_IO     = 8;
  localparam int PT_PER   = 8;
  localparam int N_LINES  = 2 * (N_IN + N_IO);
  localparam int N_SUM_PT = N_IO * PT_PER;
  localparam int PT_OE    = N_SUM_PT;
  localparam int PT_PRE   = PT_OE + N_IO;
  localparam int PT_CLR   = PT_PRE + 1;
  localparam int N_PT     = PT_CLR + 1;
  localparam int ROW_W    = 7;
  localparam int LO_W     = 32;
  localparam int HI_W     = N_LINES - LO_W;

  // ----------------------------------------------------------------
  // Macrocell configuration field
  // ----------------------------------------------------------------
  localparam int         CFG_W   = 4;
  localparam int         CFG_POL = 3;
  localparam int         CFG_REG = 2;
  localparam logic [1:0] FB_PIN  = 2'h3;
  localparam logic [1:0] FB_SUM  = 2'h2;
  localparam logic [1:0] FB_REG  = 2'h0;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_ROW   = 8'h08;
  localparam logic [7:0] REG_LO    = 8'h0c;
  localparam logic [7:0] REG_HI    = 8'h10;
  localparam logic [7:0] REG_CFG   = 8'h14;
  localparam logic [7:0] REG_VIEW  = 8'h18;
  localparam int         CTRL_ERASE = 0;
  localparam int         CTRL_SEC   = 1;
  localparam int         CTRL_RUN   = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [N_PT-1:0][N_LINES-1:0] fuse;
    logic [N_IO-1:0][CFG_W-1:0]   cfg;
    logic [N_IO-1:0]              q;
    logic [N_IO-1:0]              sum_d;
    logic                         secure;
    logic                         run;
    logic                         refused;
    logic [ROW_W-1:0]             row;
    logic [LO_W-1:0]              stage;
    logic [N_IN-1:0]              in_s1;
    logic [N_IN-1:0]              in_s2;
    logic [N_IO-1:0]              io_s1;
    logic [N_IO-1:0]              io_s2;
    apb_rsp_t                     rsp;
  } state_t;

endpackage

// file: sum_of_products_logic_array_test.sv
// Self-checking bench for the sum-of-products logic array.
// Assumes one 40 MHz clock and APB answers within a few cycles.
`timescale 1ns/1ps
module sum_of_products_logic_array_test;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  sop_pkg::apb_req_t req = '0;
  sop_pkg::apb_rsp_t rsp;
  logic [9:0]        in_pin = '0;
  logic [7:0]        io_in;
  logic [7:0]        io_out;
  logic [7:0]        io_oe_n;
  logic [7:0]        drv_val = '0;
  logic [7:0]        drv_on = '0;
  logic [31:0]       rd;
  logic              err;
  int                bad_count = 0;
  int                checked = 0;

  always #12.5 clk = ~clk;

  sop_array sop_array_i (.clk(clk), .sys_rst(sys_rst), .apb_in(req), .apb_out(rsp),
    .in_pin(in_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
  sop_board sop_board_i (.io_out(io_out), .io_oe_n(io_oe_n), .drv_val(drv_val),
    .drv_on(drv_on), .io_in(io_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic seen;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Answer is registered and stands a whole cycle: take it mid-cycle, act at the edge
    for (n = 0; n < 16; n++)
    begin
      @(negedge clk);
      seen = (rsp.pready === 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      @(posedge clk);
      if (seen)
        break;
    end
    if (n == 16)
      bad_count++;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(what, {4'h0, rd}, {4'h0, exp});
  endtask

  task automatic prog(input logic [31:0] row, input logic [35:0] pat);
    wr(sop_pkg::REG_ROW, row);
    wr(sop_pkg::REG_LO, pat[31:0]);
    wr(sop_pkg::REG_HI, {28'h0, pat[35:32]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("oe_n", io_oe_n, 8'hff);
    chk("out", io_out, 8'hff);
    rdchk("status", sop_pkg::REG_STAT, 32'h0);
    apb(1'b0, 8'h40, '0);
    chk("slverr", err, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_comb;
    logic [1:0] v;
    prog(0, 36'h9);
    for (int r = 1; r < 8; r++)
      prog(r, 36'h3);
    prog(65, 36'hf_ffff_ffff);
    wr(sop_pkg::REG_CTRL, 32'h4);
    for (int k = 0; k < 4; k++)
    begin
      v = 2'(k);
      in_pin[1:0] <= v;
      repeat (4) @(posedge clk);
      chk("comb", io_out[0], v[0] & ~v[1]);
    end
    chk("oe_n", io_oe_n, 8'h02);
    $display("test comb done");
  endtask

  task automatic t_reg;
    wr(sop_pkg::REG_CTRL, 32'h0);
    // Erased preset and clear terms are always true; tie them to quiet inputs
    prog(72, 36'h10);
    prog(73, 36'h40);
    in_pin[3:2] <= 2'b00;
    wr(sop_pkg::REG_CFG, 32'h32c);
    wr(sop_pkg::REG_CTRL, 32'h4);
    in_pin[1:0] <= 2'b01;
    repeat (5) @(posedge clk);
    chk("low", io_out[0], 1'b0);
    apb(1'b0, sop_pkg::REG_VIEW, '0);
    chk("flop", rd[7:0], 8'hff);
    in_pin[1:0] <= 2'b00;
    repeat (5) @(posedge clk);
    chk("low", io_out[0], 1'b1);
    apb(1'b0, sop_pkg::REG_VIEW, '0);
    chk("flop", rd[7:0], 8'hfe);
    $display("test reg done");
  endtask

  task automatic t_pc;
    wr(sop_pkg::REG_CTRL, 32'h0);
    prog(72, 36'h10);
    prog(73, 36'h40);
    wr(sop_pkg::REG_CTRL, 32'h4);
    in_pin[3:0] <= 4'b0100;
    repeat (4) @(posedge clk);
    apb(1'b0, sop_pkg::REG_VIEW, '0);
    chk("preset", rd[7:0], 8'hff);
    in_pin[3:0] <= 4'b1100;
    repeat (4) @(posedge clk);
    apb(1'b0, sop_pkg::REG_VIEW, '0);
    chk("both", rd[7:0], 8'h00);
    chk("cleared", io_out[0], 1'b1);
    in_pin[3:0] <= 4'b1000;
    repeat (4) @(posedge clk);
    apb(1'b0, sop_pkg::REG_VIEW, '0);
    chk("clear", rd[7:0], 8'h00);
    $display("test preset clear done");
  endtask

  task automatic t_sec;
    wr(sop_pkg::REG_CTRL, 32'h0);
    wr(sop_pkg::REG_ROW, 32'd74);
    wr(sop_pkg::REG_HI, 32'h0);
    rdchk("row range", sop_pkg::REG_STAT, 32'h4);
    wr(sop_pkg::REG_ROW, 32'd73);
    rdchk("row view", sop_pkg::REG_LO, 32'h40);
    wr(sop_pkg::REG_CTRL, 32'h2);
    wr(sop_pkg::REG_HI, 32'h0);
    rdchk("secure", sop_pkg::REG_STAT, 32'h5);
    rdchk("hidden", sop_pkg::REG_LO, 32'h0);
    wr(sop_pkg::REG_CTRL, 32'h1);
    rdchk("erased", sop_pkg::REG_LO, 32'h0);
    wr(sop_pkg::REG_CTRL, 32'h4);
    wr(sop_pkg::REG_CFG, 32'h0);
    rdchk("run lock", sop_pkg::REG_STAT, 32'h6);
    $display("test security done");
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_comb;
    t_reg;
    t_pc;
    t_sec;
    print_verdict;
  end

  // Whole run needs well under 1500 cycles; this leaves ample margin
  initial
  begin
    repeat (4000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule
